// File: bmio_ports.sv
// Behaviour
// - H direction one makes pin high-impedance input
// - H direction zero drives latch onto pin
// - H latch register reads latch, not pins
// - H pins 3..0 shared with upper address
// - Bus mode: H pin n carries address 16+n
// - H pins 7..4 shared with analog inputs
// - Analog config selects H upper nibble use
// - Bus control selects H lower nibble use
// - After reset H upper analog, reads zero
// - After reset H lower nibble is bus
// - J direction one input, zero drives latch
// - J latch register reads latch, not pins
// - 8-bit mode: J pin n is data n
// - Bus control selects J pins use
// - After reset J pins carry bus signals in 8-bit mode
// - Bus disable bit frees H pins 3..0 and J pins
module bmio_ports (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // External memory bus logic
    input  wire logic [3:0]  ext_addr_hi_i,
    input  wire logic        ext_addr_oe_i,
    input  wire logic [7:0]  ext_data_out_i,
    input  wire logic        ext_data_oe_i,
    input  wire logic        ext_8bit_mode_i,
    output logic      [7:0]  ext_data_in_o,
    // Port H pads
    input  wire logic [7:0]  port_h_pin_i,
    output logic      [7:0]  port_h_pin_o,
    output logic      [7:0]  port_h_pin_oe_o,
    // Port J pads
    input  wire logic [7:0]  port_j_pin_i,
    output logic      [7:0]  port_j_pin_o,
    output logic      [7:0]  port_j_pin_oe_o,
    // Pin use, for the bus and converter
    output logic      [3:0]  port_h_lower_nibble_bus_o,
    output logic      [3:0]  port_h_upper_nibble_analog_o,
    output logic             port_j_bus_o
);

    localparam int W = bmio_pkg::PORT_WIDTH;
    localparam int N = bmio_pkg::NIBBLE;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [W-1:0] h_dir;
        logic [W-1:0] h_lat;
        logic [W-1:0] j_dir;
        logic [W-1:0] j_lat;
        logic [W-1:0] acfg;
        logic [W-1:0] ebc;
        logic         ack;
        logic [31:0]  rdat;
        logic [N-1:0] h_lo_bus;
        logic [N-1:0] h_hi_ana;
        logic         j_bus;
    } bmio_state_t;

    bmio_state_t state;
    bmio_state_t next_state;

    // ----------------------------------------------------------------
    // Pin use decode
    // ----------------------------------------------------------------
    logic         bus_enabled;
    logic         h_lo_bus;
    logic         h_hi_analog;
    logic         j_bus;
    logic [W-1:0] h_bus_sel;
    logic [W-1:0] h_analog;
    logic [W-1:0] h_bus_out;
    logic [W-1:0] h_bus_oe;
    logic [W-1:0] j_bus_sel;
    logic [W-1:0] j_bus_oe;
    logic [W-1:0] h_val;
    logic [W-1:0] j_val;

    // Mode from the control registers
    always_comb begin
        bus_enabled = ~state.ebc[bmio_pkg::BIT_EXTERNAL_BUS_DISABLE];
        h_lo_bus    = bus_enabled;
        h_hi_analog = ~state.acfg[bmio_pkg::BIT_ANALOG_PORT_CONFIG3];
        j_bus       = bus_enabled & ext_8bit_mode_i;
    end

    // Per-bit selection vectors
    always_comb begin
        h_bus_sel = {{(W-N){1'b0}}, {N{h_lo_bus}}};
        h_analog  = {{N{h_hi_analog}}, {(W-N){1'b0}}};
        h_bus_out = {{(W-N){1'b0}}, ext_addr_hi_i};
        h_bus_oe  = {{(W-N){1'b0}}, {N{ext_addr_oe_i}}};
        j_bus_sel = {W{j_bus}};
        j_bus_oe  = {W{ext_data_oe_i}};
    end

    // ----------------------------------------------------------------
    // Pad multiplexers
    // ----------------------------------------------------------------
    bmio_pin_mux #(
        .WIDTH     (W)
    ) u_port_h (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .dir_i     (state.h_dir),
        .lat_i     (state.h_lat),
        .bus_sel_i (h_bus_sel),
        .bus_out_i (h_bus_out),
        .bus_oe_i  (h_bus_oe),
        .analog_i  (h_analog),
        .pin_i     (port_h_pin_i),
        .pin_o     (port_h_pin_o),
        .pin_oe_o  (port_h_pin_oe_o),
        .pin_val_o (h_val)
    );

    bmio_pin_mux #(
        .WIDTH     (W)
    ) u_port_j (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .dir_i     (state.j_dir),
        .lat_i     (state.j_lat),
        .bus_sel_i (j_bus_sel),
        .bus_out_i (ext_data_out_i),
        .bus_oe_i  (j_bus_oe),
        .analog_i  ({W{1'b0}}),
        .pin_i     (port_j_pin_i),
        .pin_o     (port_j_pin_o),
        .pin_oe_o  (port_j_pin_oe_o),
        .pin_val_o (j_val)
    );

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    logic         req;
    logic         wr;
    logic [W-1:0] wbyte;
    logic [W-1:0] rbyte;

    // New request, one answer per access
    always_comb begin
        req   = wb_cyc_i & wb_stb_i & ~state.ack;
        wr    = req & wb_we_i & wb_sel_i[0];
        wbyte = wb_dat_i[W-1:0];
    end

    // Read multiplexer, unmapped reads zero
    always_comb begin
        case (wb_adr_i)
            bmio_pkg::OFS_PORT_H_DIRECTION:     rbyte = state.h_dir;
            bmio_pkg::OFS_PORT_H_PINS:          rbyte = h_val;
            bmio_pkg::OFS_PORT_H_OUTPUT_LATCH:  rbyte = state.h_lat;
            bmio_pkg::OFS_PORT_J_DIRECTION:     rbyte = state.j_dir;
            bmio_pkg::OFS_PORT_J_PINS:          rbyte = j_val;
            bmio_pkg::OFS_PORT_J_OUTPUT_LATCH:  rbyte = state.j_lat;
            bmio_pkg::OFS_ANALOG_PIN_CONFIG:    rbyte = state.acfg;
            bmio_pkg::OFS_EXTERNAL_BUS_CONTROL: rbyte = state.ebc;
            default:                            rbyte = 8'h00;
        endcase
    end

    // Next state
    always_comb begin
        next_state          = state;
        next_state.ack      = req;
        next_state.rdat     = 32'h0000_0000;
        if (req && !wb_we_i) begin
            next_state.rdat = {24'h00_0000, rbyte};
        end
        // Writes land regardless of current pin use
        if (wr) begin
            case (wb_adr_i)
                bmio_pkg::OFS_PORT_H_DIRECTION: begin
                    next_state.h_dir = wbyte;
                end
                bmio_pkg::OFS_PORT_H_PINS, bmio_pkg::OFS_PORT_H_OUTPUT_LATCH: begin
                    next_state.h_lat = wbyte;
                end
                bmio_pkg::OFS_PORT_J_DIRECTION: begin
                    next_state.j_dir = wbyte;
                end
                bmio_pkg::OFS_PORT_J_PINS, bmio_pkg::OFS_PORT_J_OUTPUT_LATCH: begin
                    next_state.j_lat = wbyte;
                end
                bmio_pkg::OFS_ANALOG_PIN_CONFIG: begin
                    next_state.acfg = wbyte & bmio_pkg::MASK_ANALOG_PIN_CONFIG;
                end
                bmio_pkg::OFS_EXTERNAL_BUS_CONTROL: begin
                    next_state.ebc = wbyte & bmio_pkg::MASK_EXTERNAL_BUS_CONTROL;
                end
                default: begin
                end
            endcase
        end
        // Pin use status for neighbours
        next_state.h_lo_bus = {N{h_lo_bus}};
        next_state.h_hi_ana = {N{h_hi_analog}};
        next_state.j_bus    = j_bus;
    end

    // State register, bus pins and analog after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state.h_dir    <= bmio_pkg::RST_DIRECTION;
            state.h_lat    <= bmio_pkg::RST_OUTPUT_LATCH;
            state.j_dir    <= bmio_pkg::RST_DIRECTION;
            state.j_lat    <= bmio_pkg::RST_OUTPUT_LATCH;
            state.acfg     <= bmio_pkg::RST_ANALOG_PIN_CONFIG;
            state.ebc      <= bmio_pkg::RST_EXTERNAL_BUS_CONTROL;
            state.ack      <= 1'b0;
            state.rdat     <= 32'h0000_0000;
            state.h_lo_bus <= 4'h0;
            state.h_hi_ana <= 4'h0;
            state.j_bus    <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack_o                    = state.ack;
    assign wb_dat_o                    = state.rdat;
    assign ext_data_in_o               = j_val;
    assign port_h_lower_nibble_bus_o   = state.h_lo_bus;
    assign port_h_upper_nibble_analog_o = state.h_hi_ana;
    assign port_j_bus_o                = state.j_bus;

endmodule : bmio_ports

// File: bmio_pkg.sv
package bmio_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets on the bus
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_H_DIRECTION     = 8'h00;
    localparam logic [7:0] OFS_PORT_H_PINS          = 8'h04;
    localparam logic [7:0] OFS_PORT_H_OUTPUT_LATCH  = 8'h08;
    localparam logic [7:0] OFS_PORT_J_DIRECTION     = 8'h0C;
    localparam logic [7:0] OFS_PORT_J_PINS          = 8'h10;
    localparam logic [7:0] OFS_PORT_J_OUTPUT_LATCH  = 8'h14;
    localparam logic [7:0] OFS_ANALOG_PIN_CONFIG    = 8'h18;
    localparam logic [7:0] OFS_EXTERNAL_BUS_CONTROL = 8'h1C;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_DIRECTION            = 8'hFF;
    localparam logic [7:0] RST_OUTPUT_LATCH         = 8'h00;
    localparam logic [7:0] RST_ANALOG_PIN_CONFIG    = 8'h00;
    localparam logic [7:0] RST_EXTERNAL_BUS_CONTROL = 8'h00;

    // ----------------------------------------------------------------
    // Implemented bits and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] MASK_ANALOG_PIN_CONFIG    = 8'h3F;
    localparam logic [7:0] MASK_EXTERNAL_BUS_CONTROL = 8'hF3;
    localparam int         BIT_EXTERNAL_BUS_DISABLE  = 7;
    localparam int         BIT_ANALOG_PORT_CONFIG3   = 3;
    localparam int         BIT_WRITE_MODE_HIGH       = 1;
    localparam int         BIT_WRITE_MODE_LOW        = 0;

    // ----------------------------------------------------------------
    // Port geometry
    // ----------------------------------------------------------------
    localparam int PORT_WIDTH = 8;
    localparam int NIBBLE     = 4;

endpackage : bmio_pkg

// File: bmio_pin_mux.sv
module bmio_pin_mux #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Port registers
    input  wire logic [WIDTH-1:0] dir_i,
    input  wire logic [WIDTH-1:0] lat_i,
    // Alternate functions, per bit
    input  wire logic [WIDTH-1:0] bus_sel_i,
    input  wire logic [WIDTH-1:0] bus_out_i,
    input  wire logic [WIDTH-1:0] bus_oe_i,
    input  wire logic [WIDTH-1:0] analog_i,
    // Pads
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] pin_o,
    output logic      [WIDTH-1:0] pin_oe_o,
    // Sampled pin levels
    output logic      [WIDTH-1:0] pin_val_o
);

    typedef struct packed {
        logic [WIDTH-1:0] out;
        logic [WIDTH-1:0] oe;
        logic [WIDTH-1:0] val;
    } bmio_pin_state_t;

    bmio_pin_state_t state;
    bmio_pin_state_t next_state;

    // ----------------------------------------------------------------
    // Per-pin drive selection
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] sel_out;
    logic [WIDTH-1:0] sel_oe;
    logic [WIDTH-1:0] sel_val;

    for (genvar n = 0; n < WIDTH; n++) begin : g_pin
        // Bus owns drive, else analog off, else port registers
        always_comb begin
            if (bus_sel_i[n]) begin
                sel_out[n] = bus_out_i[n];
                sel_oe[n]  = bus_oe_i[n];
            end else if (analog_i[n]) begin
                sel_out[n] = 1'b0;
                sel_oe[n]  = 1'b0;
            end else begin
                sel_out[n] = lat_i[n];
                sel_oe[n]  = ~dir_i[n];
            end
            sel_val[n] = analog_i[n] ? 1'b0 : pin_i[n];
        end
    end

    // Next state
    always_comb begin
        next_state     = state;
        next_state.out = sel_out;
        next_state.oe  = sel_oe;
        next_state.val = sel_val;
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign pin_o     = state.out;
    assign pin_oe_o  = state.oe;
    assign pin_val_o = state.val;

endmodule : bmio_pin_mux

// File: bmio_ports_props.sv
module bmio_ports_props (
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Bus logic
    input wire logic [3:0]  ext_addr_hi_i,
    input wire logic        ext_addr_oe_i,
    input wire logic [7:0]  ext_data_out_i,
    input wire logic        ext_data_oe_i,
    input wire logic        ext_8bit_mode_i,
    // Pads and pin use
    input wire logic [7:0]  port_h_pin_o,
    input wire logic [7:0]  port_h_pin_oe_o,
    input wire logic [7:0]  port_j_pin_o,
    input wire logic [7:0]  port_j_pin_oe_o,
    input wire logic [3:0]  port_h_lower_nibble_bus_o,
    input wire logic [3:0]  port_h_upper_nibble_analog_o,
    input wire logic        port_j_bus_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Bus handshake
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    // Pin use after reset
    reset_use_a: assert property ($fell(rst_i) |=> port_h_lower_nibble_bus_o == 4'hF
        && port_h_upper_nibble_analog_o == 4'hF && port_j_bus_o == $past(ext_8bit_mode_i))
        else $error("pin use wrong after reset");
    // Pins given to analog or bus
    analog_quiet_a: assert property (port_h_upper_nibble_analog_o == 4'hF
        && $past(port_h_upper_nibble_analog_o) == 4'hF |-> port_h_pin_oe_o[7:4] == 4'h0)
        else $error("analog pin driven");
    h_addr_drive_a: assert property (port_h_lower_nibble_bus_o == 4'hF
        && $past(port_h_lower_nibble_bus_o) == 4'hF
        |-> port_h_pin_oe_o[3:0] == {4{$past(ext_addr_oe_i)}}
        && (!$past(ext_addr_oe_i) || port_h_pin_o[3:0] == $past(ext_addr_hi_i)))
        else $error("address pins wrong");
    j_data_drive_a: assert property (port_j_bus_o && $past(port_j_bus_o)
        |-> port_j_pin_oe_o == {8{$past(ext_data_oe_i)}}
        && (!$past(ext_data_oe_i) || port_j_pin_o == $past(ext_data_out_i)))
        else $error("data pins wrong");
    j_needs_bus_a: assert property (port_j_bus_o |-> port_h_lower_nibble_bus_o == 4'hF)
        else $error("data bus without bus enable");
endmodule : bmio_ports_props

bind bmio_ports bmio_ports_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_addr_hi_i(ext_addr_hi_i),
    .ext_addr_oe_i(ext_addr_oe_i), .ext_data_out_i(ext_data_out_i),
    .ext_data_oe_i(ext_data_oe_i), .ext_8bit_mode_i(ext_8bit_mode_i),
    .port_h_pin_o(port_h_pin_o), .port_h_pin_oe_o(port_h_pin_oe_o),
    .port_j_pin_o(port_j_pin_o), .port_j_pin_oe_o(port_j_pin_oe_o),
    .port_h_lower_nibble_bus_o(port_h_lower_nibble_bus_o),
    .port_h_upper_nibble_analog_o(port_h_upper_nibble_analog_o),
    .port_j_bus_o(port_j_bus_o)
);

// File: bmio_board.sv
module bmio_board (
    // Device side
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] oe_i,
    // Board side
    input  wire logic [7:0] drive_i,
    output logic      [7:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Device drive wins, board resistor drive elsewhere
    assign level_o = (pin_o_i & oe_i) | (drive_i & ~oe_i);
endmodule : bmio_board

// File: bmio_ports_tb.sv
module bmio_ports_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, port_j_bus_o;
    logic        ext_addr_oe_i, ext_data_oe_i, ext_8bit_mode_i, p;
    logic [3:0]  wb_sel_i, ext_addr_hi_i, h_lo_bus, h_hi_ana;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [7:0]  wb_adr_i, ext_data_out_i, h_pin, h_oe, h_lvl, h_drv, j_pin, j_oe, j_lvl, j_drv;
    logic [7:0]  d, l, b, q, base, j_in;
    int          seed, miscompares, total_checks, cycles;
    logic [7:0]  rv_ofs [6] = '{bmio_pkg::OFS_PORT_H_DIRECTION, bmio_pkg::OFS_PORT_H_OUTPUT_LATCH,
        bmio_pkg::OFS_PORT_J_DIRECTION, bmio_pkg::OFS_PORT_J_OUTPUT_LATCH,
        bmio_pkg::OFS_ANALOG_PIN_CONFIG, bmio_pkg::OFS_EXTERNAL_BUS_CONTROL};
    logic [7:0]  rv_exp [6] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};

    bmio_ports dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_addr_hi_i(ext_addr_hi_i),
        .ext_addr_oe_i(ext_addr_oe_i), .ext_data_out_i(ext_data_out_i),
        .ext_data_oe_i(ext_data_oe_i), .ext_8bit_mode_i(ext_8bit_mode_i), .ext_data_in_o(j_in),
        .port_h_pin_i(h_lvl), .port_h_pin_o(h_pin), .port_h_pin_oe_o(h_oe),
        .port_j_pin_i(j_lvl), .port_j_pin_o(j_pin), .port_j_pin_oe_o(j_oe),
        .port_h_lower_nibble_bus_o(h_lo_bus), .port_h_upper_nibble_analog_o(h_hi_ana),
        .port_j_bus_o(port_j_bus_o));
    bmio_board u_bh (.pin_o_i(h_pin), .oe_i(h_oe), .drive_i(h_drv), .level_o(h_lvl));
    bmio_board u_bj (.pin_o_i(j_pin), .oe_i(j_oe), .drive_i(j_drv), .level_o(j_lvl));

    // ------------------------------------------------------------
    // Clock, bus logic stimulus, timeout
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        ext_addr_hi_i  <= 4'($random(seed));
        ext_addr_oe_i  <= 1'($random(seed));
        ext_data_out_i <= 8'($random(seed));
        ext_data_oe_i  <= 1'($random(seed));
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------
    function automatic logic [7:0] pins_exp(input logic [7:0] lt, dr, bd);
        return (lt & ~dr) | (bd & dr);
    endfunction : pins_exp
    task automatic xfer(input logic we, input logic [7:0] adr, dat, input logic s);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= adr;
        wb_dat_i <= {24'h00_0000, dat};
        wb_sel_i <= {3'b000, s};
        // Wait for the answer, only the cycle ceiling ends a hang
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o[7:0];
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : xfer
    task automatic chk(input logic [7:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 93;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ext_8bit_mode_i} = 5'b10001;
        {wb_adr_i, wb_sel_i, wb_dat_i, h_drv, j_drv} = '0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            xfer(1'b0, rv_ofs[i], 8'h00, 1'b1);
            chk(q, rv_exp[i]);
        end
        h_drv <= 8'hFF;
        repeat (4) @(posedge clk_i);
        xfer(1'b0, bmio_pkg::OFS_PORT_H_PINS, 8'h00, 1'b1);
        chk(q & 8'hF0, 8'h00);
        xfer(1'b0, 8'h20, 8'h00, 1'b1);
        chk(q, 8'h00);
        $display("done: reset values");
        xfer(1'b1, bmio_pkg::OFS_ANALOG_PIN_CONFIG, 8'hFF, 1'b1);
        xfer(1'b0, bmio_pkg::OFS_ANALOG_PIN_CONFIG, 8'h00, 1'b1);
        chk(q, 8'h3F);
        xfer(1'b1, bmio_pkg::OFS_EXTERNAL_BUS_CONTROL, 8'h7F, 1'b1);
        xfer(1'b0, bmio_pkg::OFS_EXTERNAL_BUS_CONTROL, 8'h00, 1'b1);
        chk(q, 8'h73);
        // Latch and direction written while H pins 3..0 belong to the bus
        xfer(1'b1, bmio_pkg::OFS_PORT_H_OUTPUT_LATCH, 8'h5A, 1'b1);
        xfer(1'b1, bmio_pkg::OFS_PORT_H_OUTPUT_LATCH, 8'hC3, 1'b0);
        xfer(1'b1, bmio_pkg::OFS_PORT_H_DIRECTION, 8'h00, 1'b1);
        xfer(1'b0, bmio_pkg::OFS_PORT_H_OUTPUT_LATCH, 8'h00, 1'b1);
        chk(q, 8'h5A);
        xfer(1'b1, bmio_pkg::OFS_EXTERNAL_BUS_CONTROL, 8'h80, 1'b1);
        xfer(1'b1, bmio_pkg::OFS_ANALOG_PIN_CONFIG, 8'h0F, 1'b1);
        repeat (3) @(posedge clk_i);
        chk(h_pin, 8'h5A);
        chk(h_oe, 8'hFF);
        chk({port_j_bus_o, h_lo_bus, h_hi_ana[2:0]}, 8'h00);
        $display("done: pin use");
        for (int i = 0; i < 24; i++) begin
            p = i[0];
            base = p ? bmio_pkg::OFS_PORT_J_DIRECTION : bmio_pkg::OFS_PORT_H_DIRECTION;
            d = (i < 2) ? 8'h00 : (i < 4) ? 8'hFF : 8'($random(seed));
            l = 8'($random(seed));
            b = 8'($random(seed));
            h_drv <= b;
            j_drv <= b;
            xfer(1'b1, base + 8'h08, l, 1'b1);
            xfer(1'b1, base, d, 1'b1);
            repeat (4) @(posedge clk_i);
            chk(p ? j_oe : h_oe, ~d);
            chk((p ? j_pin : h_pin) & ~d, l & ~d);
            xfer(1'b0, base + 8'h08, 8'h00, 1'b1);
            chk(q, l);
            xfer(1'b0, base + 8'h04, 8'h00, 1'b1);
            chk(q, pins_exp(l, d, b));
            if (p) chk(j_in, pins_exp(l, d, b));
        end
        $display("done: random port traffic");
        ext_8bit_mode_i <= 1'b0;
        xfer(1'b1, bmio_pkg::OFS_EXTERNAL_BUS_CONTROL, 8'h00, 1'b1);
        xfer(1'b1, bmio_pkg::OFS_ANALOG_PIN_CONFIG, 8'h00, 1'b1);
        repeat (3) @(posedge clk_i);
        chk({port_j_bus_o, 3'b000, h_lo_bus}, 8'h0F);
        chk({4'h0, h_hi_ana}, 8'h0F);
        ext_8bit_mode_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({7'h00, port_j_bus_o}, 8'h01);
        repeat (8) @(posedge clk_i);
        $display("done: bus modes");
        conclude();
    end
endmodule : bmio_ports_tb
